// *** inc/dnt_pkg.sv ***
package dnt_pkg;
  // byte offsets of the channel registers on the register port
  localparam logic [7:0] OFS_SRC_ADDR  = 8'h00;
  localparam logic [7:0] OFS_DST_ADDR  = 8'h04;
  localparam logic [7:0] OFS_COUNT     = 8'h0C;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h14;
  localparam logic [7:0] OFS_ADDR_CTRL = 8'h18;
  localparam logic [7:0] OFS_MSTOP_A   = 8'h20;

  // mode control fields
  localparam int MC_ENABLE_BIT = 31;
  localparam int MC_SIZE_LO    = 14;
  localparam int MC_MODE_LO    = 12;
  localparam int MC_REQ_LO     = 6;
  // address control fields
  localparam int AC_AMS_BIT    = 31;
  localparam int AC_SRC_UPD_LO = 20;
  localparam int AC_DST_UPD_LO = 16;
  // module stop control a
  localparam int MS_DMA_BIT    = 13;

  // field encodings
  localparam logic [1:0] SIZE_BYTE    = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] REQ_AUTO     = 2'h0;
  localparam logic       AMS_DUAL     = 1'h0;
  localparam logic [1:0] UPD_INC      = 2'h2;
  localparam logic [1:0] UPD_DEC      = 2'h3;

  // values after reset
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [1:0]  RST_FIELD   = 2'h0;
  localparam logic        RST_MSTOP   = 1'h1;
  // byte access step
  localparam logic [31:0] STEP_BYTE   = 32'h0000_0001;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RD   = 2'b01,
    SEQ_WR   = 2'b10,
    SEQ_GAP  = 2'b11
  } dnt_seq_t;
endpackage : dnt_pkg

// *** src/dnt_xfer_seq.sv ***
`timescale 1ns/1ps
module dnt_xfer_seq (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // channel side
  input  wire logic        start,
  input  wire logic [31:0] src_addr,
  input  wire logic [31:0] dst_addr,
  output logic             done,
  output logic             idle,
  // internal memory bus
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack
);
  dnt_pkg::dnt_seq_t state_r, state_nxt;
  logic        req_r, req_nxt, we_r, we_nxt, done_r, done_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [7:0]  data_r, data_nxt;

  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    we_nxt    = we_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    done_nxt  = 1'b0;
    case (state_r)
      dnt_pkg::SEQ_IDLE: begin
        if (start) begin
          state_nxt = dnt_pkg::SEQ_RD;
          req_nxt   = 1'b1;
          we_nxt    = 1'b0;
          addr_nxt  = src_addr;
        end
      end
      dnt_pkg::SEQ_RD: begin
        // read first, byte held for the write
        if (mem_ack) begin
          state_nxt = dnt_pkg::SEQ_WR;
          we_nxt    = 1'b1;
          addr_nxt  = dst_addr;
          data_nxt  = mem_rdata;
        end
      end
      dnt_pkg::SEQ_WR: begin
        if (mem_ack) begin
          state_nxt = dnt_pkg::SEQ_GAP;
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          done_nxt  = 1'b1;
        end
      end
      dnt_pkg::SEQ_GAP: begin
        // bus stays released for two cycles, this one and idle, so the cpu can take it between transfers
        state_nxt = dnt_pkg::SEQ_IDLE;
      end
      default: begin
        state_nxt = dnt_pkg::SEQ_IDLE;
        req_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= dnt_pkg::SEQ_IDLE;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= dnt_pkg::RST_WORD;
      data_r  <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      done_r  <= done_nxt;
    end
  end

  assign mem_req   = req_r;
  assign mem_we    = we_r;
  assign mem_addr  = addr_r;
  assign mem_wdata = data_r;
  assign done      = done_r;
  assign idle      = (state_r == dnt_pkg::SEQ_IDLE);

  a_read_then_write: assert property (@(posedge clk) disable iff (srst)
    mem_req && !mem_we && mem_ack |=> mem_req && mem_we && mem_wdata == $past(mem_rdata))
    else $error("write does not follow read with the read byte");
  a_bus_release: assert property (@(posedge clk) disable iff (srst)
    done |-> !mem_req ##1 !mem_req)
    else $error("bus not released between transfers");
  a_write_addr: assert property (@(posedge clk) disable iff (srst)
    $rose(mem_we) |-> mem_addr == $past(dst_addr))
    else $error("write cycle not at destination");
endmodule : dnt_xfer_seq

// *** src/dnt_channel.sv ***
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - software enable starts a block move of the programmed byte count.
// - auto request, cycle stealing, normal mode, dual addressing, byte access.
// - source address register 32-bit read/write, advanced after each transfer.
// - destination address register 32-bit read/write, advanced after each transfer.
// - count register holds total bytes, reduced by access size per transfer.
// - byte access reduces count by one; reads show bytes remaining.
// - all logic runs on the system clock only.
// - module stop bit 13 halts the channel; software clears it first.
// - transfers only while enable bit 31 is one.
// - size, mode and request fields at 00 mean byte, normal, auto.
// - address mode bit 31: 0 dual, 1 single.
// - update field 10 increments the address by one per byte.
module dnt_channel (
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // internal memory bus
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack
);
  logic [31:0] source_address_r, source_address_nxt;
  logic [31:0] destination_address_r, destination_address_nxt;
  logic [31:0] transfer_count_r, transfer_count_nxt;
  logic        transfer_enable_r, transfer_enable_nxt;
  logic [1:0]  access_size_r, access_size_nxt;
  logic [1:0]  transfer_mode_r, transfer_mode_nxt;
  logic [1:0]  request_source_r, request_source_nxt;
  logic        address_mode_r, address_mode_nxt;
  logic [1:0]  src_update_r, src_update_nxt;
  logic [1:0]  dst_update_r, dst_update_nxt;
  logic        dma_module_stop_r, dma_module_stop_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] mode_word, addr_word;
  logic        cfg_ok, start, done, seq_idle;
  logic        wr_src, wr_dst, wr_cnt, wr_mode, wr_actl, wr_mstop;

  assign wr_src   = reg_wr && reg_addr == dnt_pkg::OFS_SRC_ADDR;
  assign wr_dst   = reg_wr && reg_addr == dnt_pkg::OFS_DST_ADDR;
  assign wr_cnt   = reg_wr && reg_addr == dnt_pkg::OFS_COUNT;
  assign wr_mode  = reg_wr && reg_addr == dnt_pkg::OFS_MODE_CTRL;
  assign wr_actl  = reg_wr && reg_addr == dnt_pkg::OFS_ADDR_CTRL;
  assign wr_mstop = reg_wr && reg_addr == dnt_pkg::OFS_MSTOP_A;

  // only the one supported configuration moves data
  assign cfg_ok = access_size_r == dnt_pkg::SIZE_BYTE && transfer_mode_r == dnt_pkg::MODE_NORMAL
               && request_source_r == dnt_pkg::REQ_AUTO && address_mode_r == dnt_pkg::AMS_DUAL;

  // start is withheld while done is high: registers are updating that cycle
  assign start = transfer_enable_r && !dma_module_stop_r && cfg_ok
              && transfer_count_r != dnt_pkg::RST_WORD && !done;

  always_comb begin
    mode_word = dnt_pkg::RST_WORD;
    mode_word[dnt_pkg::MC_ENABLE_BIT] = transfer_enable_r;
    mode_word[dnt_pkg::MC_SIZE_LO +: 2] = access_size_r;
    mode_word[dnt_pkg::MC_MODE_LO +: 2] = transfer_mode_r;
    mode_word[dnt_pkg::MC_REQ_LO +: 2] = request_source_r;
    addr_word = dnt_pkg::RST_WORD;
    addr_word[dnt_pkg::AC_AMS_BIT] = address_mode_r;
    addr_word[dnt_pkg::AC_SRC_UPD_LO +: 2] = src_update_r;
    addr_word[dnt_pkg::AC_DST_UPD_LO +: 2] = dst_update_r;
  end

  always_comb begin
    source_address_nxt      = source_address_r;
    destination_address_nxt = destination_address_r;
    transfer_count_nxt      = transfer_count_r;
    transfer_enable_nxt     = transfer_enable_r;
    access_size_nxt         = access_size_r;
    transfer_mode_nxt       = transfer_mode_r;
    request_source_nxt      = request_source_r;
    address_mode_nxt        = address_mode_r;
    src_update_nxt          = src_update_r;
    dst_update_nxt          = dst_update_r;
    dma_module_stop_nxt     = dma_module_stop_r;
    // hardware updates first, a software write in the same cycle overrides
    if (done) begin
      if (src_update_r == dnt_pkg::UPD_INC) begin
        source_address_nxt = source_address_r + dnt_pkg::STEP_BYTE;
      end else if (src_update_r == dnt_pkg::UPD_DEC) begin
        source_address_nxt = source_address_r - dnt_pkg::STEP_BYTE;
      end
      if (dst_update_r == dnt_pkg::UPD_INC) begin
        destination_address_nxt = destination_address_r + dnt_pkg::STEP_BYTE;
      end else if (dst_update_r == dnt_pkg::UPD_DEC) begin
        destination_address_nxt = destination_address_r - dnt_pkg::STEP_BYTE;
      end
      transfer_count_nxt = transfer_count_r - dnt_pkg::STEP_BYTE;
      if (transfer_count_nxt == dnt_pkg::RST_WORD) begin
        transfer_enable_nxt = 1'b0;
      end
    end else if (transfer_enable_r && seq_idle && transfer_count_r == dnt_pkg::RST_WORD) begin
      transfer_enable_nxt = 1'b0;
    end
    if (wr_src) begin
      source_address_nxt = reg_wdata;
    end
    if (wr_dst) begin
      destination_address_nxt = reg_wdata;
    end
    if (wr_cnt) begin
      transfer_count_nxt = reg_wdata;
    end
    if (wr_mode) begin
      transfer_enable_nxt = reg_wdata[dnt_pkg::MC_ENABLE_BIT];
      access_size_nxt     = reg_wdata[dnt_pkg::MC_SIZE_LO +: 2];
      transfer_mode_nxt   = reg_wdata[dnt_pkg::MC_MODE_LO +: 2];
      request_source_nxt  = reg_wdata[dnt_pkg::MC_REQ_LO +: 2];
    end
    if (wr_actl) begin
      address_mode_nxt = reg_wdata[dnt_pkg::AC_AMS_BIT];
      src_update_nxt   = reg_wdata[dnt_pkg::AC_SRC_UPD_LO +: 2];
      dst_update_nxt   = reg_wdata[dnt_pkg::AC_DST_UPD_LO +: 2];
    end
    if (wr_mstop) begin
      dma_module_stop_nxt = reg_wdata[dnt_pkg::MS_DMA_BIT];
    end
  end

  always_comb begin
    rdata_nxt = dnt_pkg::RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        dnt_pkg::OFS_SRC_ADDR:  rdata_nxt = source_address_r;
        dnt_pkg::OFS_DST_ADDR:  rdata_nxt = destination_address_r;
        dnt_pkg::OFS_COUNT:     rdata_nxt = transfer_count_r;
        dnt_pkg::OFS_MODE_CTRL: rdata_nxt = mode_word;
        dnt_pkg::OFS_ADDR_CTRL: rdata_nxt = addr_word;
        dnt_pkg::OFS_MSTOP_A:   rdata_nxt[dnt_pkg::MS_DMA_BIT] = dma_module_stop_r;
        default:                rdata_nxt = dnt_pkg::RST_WORD;
      endcase
    end
  end

  // single system clock domain, no peripheral clock
  always_ff @(posedge clk) begin
    if (srst) begin
      source_address_r      <= dnt_pkg::RST_WORD;
      destination_address_r <= dnt_pkg::RST_WORD;
      transfer_count_r      <= dnt_pkg::RST_WORD;
      transfer_enable_r     <= 1'b0;
      access_size_r         <= dnt_pkg::RST_FIELD;
      transfer_mode_r       <= dnt_pkg::RST_FIELD;
      request_source_r      <= dnt_pkg::RST_FIELD;
      address_mode_r        <= 1'b0;
      src_update_r          <= dnt_pkg::RST_FIELD;
      dst_update_r          <= dnt_pkg::RST_FIELD;
      dma_module_stop_r     <= dnt_pkg::RST_MSTOP;
      rdata_r               <= dnt_pkg::RST_WORD;
    end else begin
      source_address_r      <= source_address_nxt;
      destination_address_r <= destination_address_nxt;
      transfer_count_r      <= transfer_count_nxt;
      transfer_enable_r     <= transfer_enable_nxt;
      access_size_r         <= access_size_nxt;
      transfer_mode_r       <= transfer_mode_nxt;
      request_source_r      <= request_source_nxt;
      address_mode_r        <= address_mode_nxt;
      src_update_r          <= src_update_nxt;
      dst_update_r          <= dst_update_nxt;
      dma_module_stop_r     <= dma_module_stop_nxt;
      rdata_r               <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  dnt_xfer_seq u_seq (
    .clk       (clk),
    .srst      (srst),
    .start     (start),
    .src_addr  (source_address_r),
    .dst_addr  (destination_address_r),
    .done      (done),
    .idle      (seq_idle),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack)
  );

  a_count_dec: assert property (@(posedge clk) disable iff (srst)
    done && !wr_cnt |=> transfer_count_r == $past(transfer_count_r) - 32'h0000_0001)
    else $error("count not reduced by one after transfer");
  a_src_inc: assert property (@(posedge clk) disable iff (srst)
    done && !wr_src && src_update_r == 2'h2 |=> source_address_r == $past(source_address_r) + 32'h0000_0001)
    else $error("source address not incremented");
  a_dst_inc: assert property (@(posedge clk) disable iff (srst)
    done && !wr_dst && dst_update_r == 2'h2 |=> destination_address_r == $past(destination_address_r) + 32'h0000_0001)
    else $error("destination address not incremented");
  a_end_clear: assert property (@(posedge clk) disable iff (srst)
    done && !wr_mode && transfer_count_r == 32'h0000_0001 |=> !transfer_enable_r ##1 !mem_req)
    else $error("enable not cleared at end of block");
  a_start_gate: assert property (@(posedge clk) disable iff (srst)
    $rose(mem_req) |-> $past(transfer_enable_r && !dma_module_stop_r && cfg_ok))
    else $error("transfer started while disabled or stopped");
  a_stop_hold: assert property (@(posedge clk) disable iff (srst)
    dma_module_stop_r && seq_idle |=> !mem_req)
    else $error("transfer started in module stop");
  a_read_src: assert property (@(posedge clk) disable iff (srst)
    $rose(mem_req) |-> !mem_we && mem_addr == $past(source_address_r))
    else $error("transfer does not open with source read");
  a_rdata_slot: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == dnt_pkg::OFS_COUNT |=> reg_rdata == $past(transfer_count_r))
    else $error("count read data wrong");

  c_block_end: cover property (@(posedge clk) disable iff (srst) done ##1 !transfer_enable_r);
  c_back_to_back: cover property (@(posedge clk) disable iff (srst) done ##2 $rose(mem_req));
  c_stop_cleared: cover property (@(posedge clk) disable iff (srst) $fell(dma_module_stop_r));
endmodule : dnt_channel

// *** verif/dnt_mem_model.sv ***
`timescale 1ns/1ps
module dnt_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // answer delay in cycles
  input  wire logic [3:0]  ack_wait,
  // internal memory bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_cnt;
  // rom half holds its index, ram half starts filled with EE
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = (i < 128) ? 8'(i) : 8'hEE;
    end
  end
  // one ack per access; read data only beside the ack, toggling otherwise
  always @(posedge clk) begin
    if (srst || mem_ack) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (mem_req && wait_cnt >= ack_wait) begin
      mem_ack <= 1'b1;
    end else if (mem_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
    if (srst) begin
      mem_rdata <= 8'h5A;
    end else if (mem_req && !mem_we && !mem_ack && wait_cnt >= ack_wait) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_ack && mem_we) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule : dnt_mem_model

// *** verif/dnt_channel_tb.sv ***
`timescale 1ns/1ps
module dnt_channel_tb;
  localparam logic [7:0] A_SRC = dnt_pkg::OFS_SRC_ADDR;
  localparam logic [7:0] A_DST = dnt_pkg::OFS_DST_ADDR;
  localparam logic [7:0] A_CNT = dnt_pkg::OFS_COUNT;
  localparam logic [7:0] A_MOD = dnt_pkg::OFS_MODE_CTRL;
  localparam logic [7:0] A_ACT = dnt_pkg::OFS_ADDR_CTRL;
  localparam logic [7:0] A_STP = dnt_pkg::OFS_MSTOP_A;
  logic clk, srst, reg_wr, reg_rd, mem_req, mem_we, mem_ack, rd_seen;
  logic [7:0] reg_addr, mem_wdata, mem_rdata, last_byte;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, exp_src, exp_dst, d, prev, step;
  logic [3:0] ack_wait;
  int failures, n_checks;
  logic [31:0] t_mode [5] = '{32'h8000_4000, 32'h8000_1000, 32'h8000_0040, 32'h8000_0000, 32'h8000_0000};
  logic [31:0] t_act [5] = '{32'h0022_0000, 32'h0022_0000, 32'h0022_0000, 32'h8022_0000, 32'h0022_0000};
  logic [31:0] t_stp [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_2000};

  dnt_channel dnt_channel_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  dnt_mem_model dnt_mem_model_i (.clk(clk), .srst(srst), .ack_wait(ack_wait), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic end_sim;
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // an edge passes after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    cmp(name, exp, v);
  endtask : chk

  // block move, count polled until empty, then addresses, enable and bytes checked; dn walks addresses down
  task automatic run(input logic [31:0] s, input logic [31:0] t, input logic [31:0] n, input logic [3:0] w,
                     input logic dn);
    ack_wait <= w;
    step = dn ? 32'hFFFF_FFFF : 32'h1;
    exp_src = s;
    exp_dst = t;
    rd_seen = 1'b0;
    prev = n;
    wr(A_SRC, s);
    wr(A_DST, t);
    wr(A_CNT, n);
    wr(A_ACT, dn ? 32'h0033_0000 : 32'h0022_0000);
    wr(A_MOD, 32'h8000_0000);
    for (int i = 0; i < 2000 && prev !== 32'h0; i++) begin
      rd(A_CNT, d);
      cmp("count step", 32'h1, 32'(d <= prev && prev - d <= 32'h1));
      prev = d;
    end
    if (prev !== 32'h0) begin
      failures++;
      end_sim();
    end
    chk("source after", A_SRC, s + n * step);
    chk("dest after", A_DST, t + n * step);
    chk("count after", A_CNT, 32'h0);
    chk("enable after", A_MOD, 32'h0);
    for (int i = 0; i < n; i++) begin
      cmp("moved byte", {24'h0, 8'(s + i * step)}, {24'h0, dnt_mem_model_i.mem[8'(t + i * step)]});
    end
  endtask : run

  // every access checked against expected address; write carries byte just read
  always @(posedge clk) begin
    if (mem_ack && !mem_we) begin
      cmp("read addr", exp_src, mem_addr);
      last_byte = mem_rdata;
      rd_seen = 1'b1;
      exp_src = exp_src + step;
    end else if (mem_ack) begin
      cmp("write order", 32'h1, {31'h0, rd_seen});
      cmp("write addr", exp_dst, mem_addr);
      cmp("write data", {24'h0, last_byte}, {24'h0, mem_wdata});
      rd_seen = 1'b0;
      exp_dst = exp_dst + step;
    end
  end

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ack_wait = 4'h0;
    failures = 0;
    n_checks = 0;
    exp_src = 32'h0;
    exp_dst = 32'h0;
    rd_seen = 1'b0;
    step = 32'h1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("source reset", A_SRC, 32'h0);
    chk("dest reset", A_DST, 32'h0);
    chk("count reset", A_CNT, 32'h0);
    chk("mode reset", A_MOD, 32'h0);
    chk("addr ctrl reset", A_ACT, 32'h0);
    chk("stop reset", A_STP, 32'h0000_2000);
    wr(A_SRC, 32'hA5C3_0F1E);
    chk("source rw", A_SRC, 32'hA5C3_0F1E);
    wr(A_DST, 32'h5A3C_F0E1);
    chk("dest rw", A_DST, 32'h5A3C_F0E1);
    wr(8'h08, 32'hFFFF_FFFF);
    chk("unmapped", 8'h08, 32'h0);
    // sizes, modes, requests, single addressing and stop must all stay off the bus
    for (int k = 0; k < 5; k++) begin
      wr(A_STP, t_stp[k]);
      wr(A_CNT, 32'h2);
      wr(A_ACT, t_act[k]);
      wr(A_MOD, t_mode[k]);
      repeat (16) begin
        @(negedge clk);
        cmp("bus idle", 32'h0, {31'h0, mem_req});
      end
      @(posedge clk);
      wr(A_MOD, 32'h0);
    end
    wr(A_STP, 32'h0);
    // enable with an empty count must drop back without touching the bus
    wr(A_CNT, 32'h0);
    wr(A_MOD, 32'h8000_0000);
    chk("enable empty", A_MOD, 32'h0);
    run(32'h0, 32'h80, 32'h80, 4'h0, 1'b0);
    run(32'h10, 32'hF0, 32'h3, 4'h3, 1'b0);
    run(32'h20, 32'hC0, 32'h4, 4'h1, 1'b1);
    end_sim();
  end
endmodule : dnt_channel_tb
